// ---- hw/asc_pkg.sv ----
package asc_pkg;

  localparam int CMD_W  = 4;
  localparam int CFG_W  = 12;
  localparam int FRM_W  = 16;
  localparam int RES_W  = 12;
  localparam int CNT_W  = 5;

  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS   = 5'h04;

  localparam logic [3:0] CMD_CH7      = 4'h7;
  localparam logic [3:0] CMD_PWDN     = 4'h8;
  localparam logic [3:0] CMD_CFG_RD   = 4'h9;
  localparam logic [3:0] CMD_CFG_WR   = 4'hA;
  localparam logic [3:0] CMD_TST_MID  = 4'hB;
  localparam logic [3:0] CMD_TST_LOW  = 4'hC;
  localparam logic [3:0] CMD_TST_HIGH = 4'hD;
  localparam logic [3:0] CMD_BUF_RD   = 4'hE;
  localparam logic [3:0] CMD_RSVD     = 4'hF;

  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam int CFG_REF_SEL  = 11;
  localparam int CFG_REF_LVL  = 10;
  localparam int CFG_SAMP_LNG = 9;
  localparam int CFG_CCLK_HI  = 8;
  localparam int CFG_CCLK_LO  = 7;
  localparam int CFG_MODE_HI  = 6;
  localparam int CFG_MODE_LO  = 5;
  localparam int CFG_SEQ_HI   = 4;
  localparam int CFG_SEQ_LO   = 3;
  localparam int CFG_PIN_EOC  = 2;
  localparam int CFG_TRIG_HI  = 1;
  localparam int CFG_TRIG_LO  = 0;

  localparam logic [4:0] SAMP_SHORT = 5'h0C;
  localparam logic [4:0] SAMP_LONG  = 5'h18;
  localparam logic [3:0] RES_PAD    = 4'h0;

  // test input select codes
  localparam logic [1:0] TST_NONE = 2'h0;
  localparam logic [1:0] TST_MID  = 2'h1;
  localparam logic [1:0] TST_LOW  = 2'h2;
  localparam logic [1:0] TST_HIGH = 2'h3;

  typedef struct packed {
    logic       ref_internal;
    logic       ref_2v;
    logic [4:0] sample_clocks;
    logic [1:0] conv_clk_sel;
    logic [1:0] conv_mode;
    logic [1:0] sweep_order;
    logic       pin_is_eoc;
    logic [1:0] trigger_level;
  } asc_setup_t;

  typedef struct packed {
    logic       sel_valid;
    logic [2:0] channel;
    logic [1:0] test_sel;
  } asc_select_t;

endpackage : asc_pkg

// ---- hw/asc_edge.sv ----
`timescale 1ns/1ps
module asc_edge (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic sig,
  output logic      rise,
  output logic      fall,
  output logic      level
);
  typedef struct packed {
    logic prev;
  } asc_edge_st_t;

  asc_edge_st_t st_reg;
  asc_edge_st_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.prev = sig;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{prev: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise  = sig & ~st_reg.prev;
  assign fall  = ~sig & st_reg.prev;
  assign level = st_reg.prev;
endmodule : asc_edge

// ---- hw/asc_decode.sv ----
`timescale 1ns/1ps
module asc_decode (
  input  wire logic [3:0]  cmd,
  input  wire logic        four_input,
  output asc_pkg::asc_select_t sel,
  output logic             is_pwdn,
  output logic             is_cfg_rd,
  output logic             is_cfg_wr,
  output logic             is_buf_rd
);
  import asc_pkg::*;

  always_comb begin
    sel       = '{sel_valid: 1'b0, channel: 3'h0, test_sel: TST_NONE};
    is_pwdn   = 1'b0;
    is_cfg_rd = 1'b0;
    is_cfg_wr = 1'b0;
    is_buf_rd = 1'b0;
    case (cmd)
      CMD_PWDN:     is_pwdn = 1'b1;
      CMD_CFG_RD:   is_cfg_rd = 1'b1;
      CMD_CFG_WR:   is_cfg_wr = 1'b1;
      CMD_TST_MID:  sel = '{sel_valid: 1'b1, channel: 3'h0, test_sel: TST_MID};
      CMD_TST_LOW:  sel = '{sel_valid: 1'b1, channel: 3'h0, test_sel: TST_LOW};
      CMD_TST_HIGH: sel = '{sel_valid: 1'b1, channel: 3'h0, test_sel: TST_HIGH};
      CMD_BUF_RD:   is_buf_rd = 1'b1;
      CMD_RSVD:     ;
      default: begin
        // channel codes; odd ones absent on the four-input variant
        if (cmd <= CMD_CH7) begin
          if (!four_input) begin
            sel = '{sel_valid: 1'b1, channel: cmd[2:0], test_sel: TST_NONE};
          end else if (!cmd[0]) begin
            sel = '{sel_valid: 1'b1, channel: {1'b0, cmd[2:1]}, test_sel: TST_NONE};
          end
        end
      end
    endcase
  end
endmodule : asc_decode

// ---- hw/asc_serial_cmd.sv ----
`timescale 1ns/1ps
// Behaviour
// - 16-bit frames, MSB first, 4-bit command
// - setup read returns setup in low 12
// - results in bits 15..4, zeros below
// - results straight binary, 000h lowest
// - first conversion after wake flagged invalid
// - frame sync high: select fall starts frame
// - frame sync fall starts frame in DSP mode
// - codes 0..7 select inputs, variant-aware
// - code 8h enters software power down
// - code Ah loads following 12 bits
// - codes Bh..Dh select reference test inputs
// - setup survives hardware and software power down
// - setup write tolerates clock pause mid-frame
// - bit 11 reference source, bit 10 level
// - bit 9 chooses 12 or 24 sample clocks
// - bits 8..7 choose conversion clock
// - bits 6..5 choose conversion mode
// - bits 4..3 choose sweep order
// - bit 2 chooses status pin function
// - bits 1..0 choose buffer trigger level
// - latch rising edge, or falling with frame sync
// - output floats outside the 16 bits
module asc_serial_cmd (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                select_n,
  input  wire logic                frame_sync_in,
  input  wire logic                serial_clk,
  input  wire logic                serial_in,
  input  wire logic                four_input,
  input  wire logic                hardware_sleep_pin,
  input  wire logic [11:0]         result_data,
  input  wire logic                result_done,
  input  wire logic [11:0]         buffer_data,
  output logic                     serial_out,
  output logic                     serial_out_oe_n,
  output asc_pkg::asc_setup_t      setup,
  output asc_pkg::asc_select_t     input_select,
  output logic                     select_strobe,
  output logic                     buffer_pop,
  output logic                     powered_down,
  output logic                     result_invalid
);
  import asc_pkg::*;

  typedef struct packed {
    logic              dsp_mode;
    logic              in_frame;
    logic [CNT_W-1:0]  bit_cnt;
    logic [FRM_W-1:0]  shift_in;
    logic [FRM_W-1:0]  shift_out;
    logic [CMD_W-1:0]  cmd;
    logic [CFG_W-1:0]  cfg;
    logic              sdo;
    logic              sdo_oe_n;
    asc_setup_t        setup;
    asc_select_t       sel;
    logic              sel_stb;
    logic              pop;
    logic              pwdn;
    logic              first_invalid;
  } asc_state_t;

  asc_state_t st_reg;
  asc_state_t st_next;

  logic        cs_rise;
  logic        cs_fall;
  logic        cs_lvl;
  logic        fs_rise;
  logic        fs_fall;
  logic        fs_lvl;
  logic        sck_rise;
  logic        sck_fall;
  logic        sck_lvl;
  asc_select_t dec_sel;
  logic        dec_pwdn;
  logic        dec_cfg_rd;
  logic        dec_cfg_wr;
  logic        dec_buf_rd;
  logic [3:0]  cmd_now;
  logic        sample_edge;
  logic        shift_edge;

  asc_edge u_cs (
    .clk   (clk),
    .reset (reset),
    .sig   (select_n),
    .rise  (cs_rise),
    .fall  (cs_fall),
    .level (cs_lvl)
  );

  asc_edge u_fs (
    .clk   (clk),
    .reset (reset),
    .sig   (frame_sync_in),
    .rise  (fs_rise),
    .fall  (fs_fall),
    .level (fs_lvl)
  );

  asc_edge u_sck (
    .clk   (clk),
    .reset (reset),
    .sig   (serial_clk),
    .rise  (sck_rise),
    .fall  (sck_fall),
    .level (sck_lvl)
  );

  assign cmd_now = {st_reg.shift_in[2:0], serial_in};

  asc_decode u_dec (
    .cmd        (cmd_now),
    .four_input (four_input),
    .sel        (dec_sel),
    .is_pwdn    (dec_pwdn),
    .is_cfg_rd  (dec_cfg_rd),
    .is_cfg_wr  (dec_cfg_wr),
    .is_buf_rd  (dec_buf_rd)
  );

  assign sample_edge = st_reg.dsp_mode ? sck_fall : sck_rise;
  assign shift_edge  = st_reg.dsp_mode ? sck_fall : sck_rise;

  function automatic asc_setup_t unpack_cfg(input logic [11:0] c);
    asc_setup_t s;
    s.ref_internal  = c[CFG_REF_SEL];
    s.ref_2v        = c[CFG_REF_LVL];
    s.sample_clocks = c[CFG_SAMP_LNG] ? SAMP_LONG : SAMP_SHORT;
    s.conv_clk_sel  = c[CFG_CCLK_HI:CFG_CCLK_LO];
    s.conv_mode     = c[CFG_MODE_HI:CFG_MODE_LO];
    s.sweep_order   = c[CFG_SEQ_HI:CFG_SEQ_LO];
    s.pin_is_eoc    = c[CFG_PIN_EOC];
    s.trigger_level = c[CFG_TRIG_HI:CFG_TRIG_LO];
    return s;
  endfunction : unpack_cfg

  always_comb begin
    st_next         = st_reg;
    st_next.sel_stb = 1'b0;
    st_next.pop     = 1'b0;

    // sleep request wins over a result in the same cycle
    if (result_done) begin
      st_next.first_invalid = 1'b0;
    end
    if (!hardware_sleep_pin) begin
      st_next.pwdn          = 1'b1;
      st_next.first_invalid = 1'b1;
    end

    // frame start; msb presented right away
    if (cs_fall) begin
      st_next.dsp_mode = ~frame_sync_in;
      st_next.in_frame = frame_sync_in;
      st_next.bit_cnt  = '0;
      st_next.sdo      = st_reg.shift_out[15];
      st_next.sdo_oe_n = ~frame_sync_in;
    end else if (st_reg.dsp_mode && !cs_lvl && fs_fall) begin
      st_next.in_frame = 1'b1;
      st_next.bit_cnt  = '0;
      st_next.sdo      = st_reg.shift_out[15];
      st_next.sdo_oe_n = 1'b0;
    end else if (cs_rise) begin
      st_next.in_frame = 1'b0;
      st_next.sdo_oe_n = 1'b1;
    end else if (st_reg.in_frame && !cs_lvl) begin
      // clock pauses simply hold the count
      if (sample_edge) begin
        st_next.shift_in = {st_reg.shift_in[14:0], serial_in};
        st_next.bit_cnt   = st_reg.bit_cnt + 5'h01;
        st_next.shift_out = {st_reg.shift_out[14:0], 1'b0};
        st_next.sdo       = st_reg.shift_out[14];
        if (st_reg.bit_cnt == CMD_BITS - 5'h01) begin
          st_next.cmd = cmd_now;
          if (dec_sel.sel_valid) begin
            st_next.sel     = dec_sel;
            st_next.sel_stb = 1'b1;
            if (st_reg.pwdn) begin
              st_next.pwdn = 1'b0;
            end
          end
          if (dec_pwdn) begin
            st_next.pwdn          = 1'b1;
            st_next.first_invalid = 1'b1;
          end
          // setup lands so its msb follows the 4th edge
          if (dec_cfg_rd) begin
            st_next.shift_out = {st_reg.cfg, RES_PAD};
            st_next.sdo       = st_reg.cfg[CFG_W-1];
          end
        end
        if (st_reg.bit_cnt == FRAME_BITS - 5'h01) begin
          st_next.in_frame = 1'b0;
          st_next.sdo_oe_n = 1'b1;
          if (st_reg.cmd == CMD_CFG_WR) begin
            st_next.cfg   = {st_reg.shift_in[10:0], serial_in};
            st_next.setup = unpack_cfg({st_reg.shift_in[10:0], serial_in});
          end
          // word is shown in the following frame
          if (st_reg.cmd == CMD_BUF_RD) begin
            st_next.pop = 1'b1;
          end
        end
      end
    end

    // next frame's output word
    if (!st_reg.in_frame && !st_next.in_frame) begin
      if (result_done) begin
        st_next.shift_out = {result_data, RES_PAD};
      end else if (st_reg.pop) begin
        st_next.shift_out = {buffer_data, RES_PAD};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{dsp_mode: 1'b0, in_frame: 1'b0, bit_cnt: 5'h00, shift_in: 16'h0000,
                 shift_out: 16'h0000, cmd: 4'h0, cfg: CFG_RESET, sdo: 1'b0,
                 sdo_oe_n: 1'b1, setup: '0, sel: '0, sel_stb: 1'b0, pop: 1'b0,
                 pwdn: 1'b0, first_invalid: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_out      = st_reg.sdo;
  assign serial_out_oe_n = st_reg.sdo_oe_n;
  assign setup           = st_reg.setup;
  assign input_select    = st_reg.sel;
  assign select_strobe   = st_reg.sel_stb;
  assign buffer_pop      = st_reg.pop;
  assign powered_down    = st_reg.pwdn;
  assign result_invalid  = st_reg.first_invalid;
endmodule : asc_serial_cmd

// ---- tb/asc_serial_cmd_sva.sv ----
`timescale 1ns/1ps
module asc_serial_cmd_sva (
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            select_n,
  input wire logic            four_input,
  input wire logic            serial_out_oe_n,
  input asc_pkg::asc_setup_t  setup,
  input asc_pkg::asc_select_t input_select,
  input wire logic            select_strobe,
  input wire logic            buffer_pop,
  input wire logic            powered_down,
  input wire logic            result_invalid
);
  import asc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_float; select_n [*4] |-> serial_out_oe_n; endproperty
  a_float: assert property (p_float) else $error("output driven while deselected");
  property p_drive; $fell(serial_out_oe_n) |-> !select_n; endproperty
  a_drive: assert property (p_drive) else $error("output enabled without select");
  property p_strobe; select_strobe |=> !select_strobe; endproperty
  a_strobe: assert property (p_strobe) else $error("select strobe too long");
  property p_pop; buffer_pop |=> !buffer_pop; endproperty
  a_pop: assert property (p_pop) else $error("buffer pop too long");
  property p_valid; select_strobe |-> ##[0:1] input_select.sel_valid; endproperty
  a_valid: assert property (p_valid) else $error("strobe without valid select");
  property p_four;
    select_strobe && four_input |->
      ##[0:1] (input_select.test_sel != TST_NONE || !input_select.channel[2]);
  endproperty
  a_four: assert property (p_four) else $error("four-input channel out of range");
  property p_setup; $changed(setup) |-> !$past(select_n, 2); endproperty
  a_setup: assert property (p_setup) else $error("setup changed outside a frame");
  property p_wake; $rose(powered_down) |-> ##[0:2] result_invalid; endproperty
  a_wake: assert property (p_wake) else $error("sleep without invalid flag");
endmodule : asc_serial_cmd_sva

bind asc_serial_cmd asc_serial_cmd_sva chk_u (.*);

// ---- tb/asc_host_model.sv ----
`timescale 1ns/1ps
module asc_host_model (
  input  wire logic clk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n,
  output logic      select_n,
  output logic      frame_sync_in,
  output logic      serial_clk,
  output logic      serial_in
);
  initial begin
    select_n = 1'h1;
    frame_sync_in = 1'h1;
    serial_clk = 1'h0;
    serial_in = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one 16-bit frame; fsm picks frame sync framing
  task automatic xfer(input logic fsm, input logic [15:0] tx, input int pause,
                      output logic [15:0] rx);
    tick(1);
    frame_sync_in <= !fsm;
    select_n <= 1'h0;
    tick(4);
    if (fsm) begin
      frame_sync_in <= 1'h1;
      tick(4);
      frame_sync_in <= 1'h0;
      tick(4);
    end
    for (int i = 15; i >= 0; i--) begin
      serial_in <= tx[i];
      serial_clk <= fsm;
      tick(4);
      if (i == 7) tick(pause);
      rx[i] = serial_out_oe_n ? 1'bx : serial_out;
      serial_clk <= !fsm;
      tick(4);
    end
    serial_clk <= 1'h0;
    serial_in <= !tx[0];
    tick(4);
    select_n <= 1'h1;
    frame_sync_in <= 1'h1;
    tick(4);
  endtask : xfer
endmodule : asc_host_model

// ---- tb/asc_serial_cmd_bench.sv ----
`timescale 1ns/1ps
module asc_serial_cmd_bench;
  import asc_pkg::*;
  typedef struct packed {
    logic        fsm;
    logic [7:0]  pause;
    logic [11:0] val;
    logic        rd;
  } asc_row_t;
  logic        clk, reset, four_input, hardware_sleep_pin, result_done;
  logic [11:0] result_data, buffer_data;
  logic        select_n, frame_sync_in, serial_clk, serial_in, serial_out, serial_out_oe_n;
  logic        select_strobe, buffer_pop, powered_down, result_invalid;
  asc_setup_t  setup, s;
  asc_select_t input_select;
  logic [15:0] rx;
  int          err_count, samples_checked, strobes, pops, n;
  asc_row_t    rows [8] = '{'{1'h0, 8'h00, 12'hF9F, 1'h1}, '{1'h1, 8'h00, 12'h100, 1'h1},
                            '{1'h0, 8'h28, 12'h584, 1'h1}, '{1'h1, 8'h28, 12'hE1B, 1'h1},
                            '{1'h0, 8'h00, 12'h020, 1'h0}, '{1'h0, 8'h00, 12'h040, 1'h0},
                            '{1'h0, 8'h00, 12'h060, 1'h0}, '{1'h0, 8'h00, 12'h000, 1'h1}};

  asc_serial_cmd dut_u (.*);
  asc_host_model host_u (.*);

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    strobes += select_strobe;
    pops += buffer_pop;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic asc_setup_t exp_setup(input logic [11:0] v);
    return '{v[11], v[10], v[9] ? SAMP_LONG : SAMP_SHORT, v[8:7], v[6:5], v[4:3], v[2], v[1:0]};
  endfunction : exp_setup

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end

  initial begin
    reset = 1'h1;
    four_input = 1'h0;
    hardware_sleep_pin = 1'h1;
    result_done = 1'h0;
    result_data = 12'h000;
    buffer_data = 12'h000;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    host_u.xfer(1'h0, 16'hA000, 0, rx);
    for (int i = 0; i < 8; i++) begin
      host_u.xfer(rows[i].fsm, {CMD_CFG_WR, rows[i].val}, rows[i].pause, rx);
      chk("setup", exp_setup(rows[i].val), setup);
      if (rows[i].rd) begin
        host_u.xfer(1'h0, 16'h9000, 0, rx);
        chk("setup read", {4'h0, rows[i].val}, {4'h0, rx[11:0]});
      end
      $display("row %0d done", i);
    end
    for (int c = 0; c < 16; c++) begin
      four_input <= c[3];
      n = strobes + !(c[3] && c[0]);
      host_u.xfer(1'h0, {1'h0, c[2:0], 12'h000}, 0, rx);
      chk("strobes", n, strobes);
      if (!(c[3] && c[0])) chk("channel", c[3] ? c[2:1] : c[2:0], input_select.channel);
    end
    four_input <= 1'h0;
    for (int t = 0; t < 3; t++) begin
      host_u.xfer(1'h0, {4'(CMD_TST_MID + t), 12'h000}, 0, rx);
      chk("test input", TST_MID + t, input_select.test_sel);
    end
    $display("select test done");
    buffer_data <= 12'hA5C;
    n = pops + 1;
    host_u.xfer(1'h0, {CMD_BUF_RD, 12'h000}, 0, rx);
    chk("pops", n, pops);
    host_u.xfer(1'h0, {CMD_RSVD, 12'h000}, 0, rx);
    chk("buffer word", 16'hA5C0, rx);
    result_data <= 12'h3E7;
    result_done <= 1'h1;
    @(posedge clk);
    result_done <= 1'h0;
    host_u.xfer(1'h0, 16'h0000, 0, rx);
    chk("result", 16'h3E70, rx);
    chk("invalid", 16'h0000, result_invalid);
    $display("result test done");
    host_u.xfer(1'h0, 16'hA81C, 0, rx);
    host_u.xfer(1'h0, 16'h8000, 0, rx);
    chk("sleep", 16'h0001, powered_down);
    chk("invalid", 16'h0001, result_invalid);
    s = setup;
    host_u.xfer(1'h0, 16'hF123, 0, rx);
    chk("reserved", s, setup);
    chk("sleep", 16'h0001, powered_down);
    hardware_sleep_pin <= 1'h0;
    repeat (8) @(posedge clk);
    hardware_sleep_pin <= 1'h1;
    host_u.xfer(1'h0, 16'h9000, 0, rx);
    chk("kept", exp_setup(12'h81C), setup);
    chk("kept read", 16'h081C, {4'h0, rx[11:0]});
    $display("power test done");
    tally_and_finish;
  end
endmodule : asc_serial_cmd_bench
